// ### rtl/scs_sequencer.sv
// Scan-cycle sequencer for a small programmable controller
`timescale 1ns/1ps
module scs_sequencer (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Mode and field pins
  input wire logic RUN_MODE,
  input wire logic [scs_pkg::DIN_W-1:0] DIN_PINS,
  output logic [scs_pkg::DOUT_W-1:0] DOUT_PINS,
  // Program engine
  input wire scs_pkg::scs_prog_t PROG_REQ,
  output logic [scs_pkg::PC_W-1:0] PROG_PC,
  output logic PROG_EXEC,
  output logic NEST_FAULT,
  // Image access from the program
  input wire logic IMG_WR,
  input wire logic [scs_pkg::DOUT_W-1:0] IMG_OUT_DATA,
  input wire logic IMM_IN_RD,
  input wire logic IMM_OUT_WR,
  output logic [scs_pkg::DIN_W-1:0] IMG_IN_DATA,
  // Interrupt events
  input wire logic INT_EVENT,
  input wire logic INT_DONE,
  output logic INT_ACTIVE,
  // Local memory
  input wire logic LOC_WR,
  input wire logic [scs_pkg::LOC_AW-1:0] LOC_ADDR,
  input wire logic [7:0] LOC_WDATA,
  output logic [7:0] LOC_RDATA,
  // Analog inputs
  input wire logic [scs_pkg::AIN_N-1:0] AIN_FILT_EN,
  input wire logic AIN_RD,
  input wire logic [1:0] AIN_SEL,
  input wire logic [scs_pkg::AIN_N*16-1:0] AIN_MODULE,
  input wire logic [15:0] ADC_WORD0,
  input wire logic [15:0] ADC_WORD2,
  output logic [15:0] AIN_DATA,
  output logic [15:0] ONBOARD_WORD_ZERO,
  output logic [15:0] ONBOARD_WORD_TWO,
  // Analog output
  input wire logic AOUT_WR,
  input wire logic [15:0] AOUT_WDATA,
  output logic [15:0] AOUT_DATA,
  // Communications and self-test
  input wire logic COMM_PENDING,
  output logic COMM_SERVICE,
  input wire logic CPU_OK,
  input wire logic [scs_pkg::AIN_N-1:0] EXP_STATUS,
  output logic [scs_pkg::AIN_N-1:0] EXP_STATUS_IMG,
  output logic SELF_TEST_FAIL,
  output logic [2:0] SCAN_PHASE
);
  import scs_pkg::*;

  scs_phase_t phase_ff, nxt_phase;
  logic [DIN_W-1:0] din_s1_ff, din_s2_ff, in_img_ff;
  logic [DOUT_W-1:0] out_img_ff, dout_ff;
  logic [PC_W-1:0] pc_ff;
  logic [3:0] nest_ff;
  // Interrupt depth kept apart so a return to main finds its own nesting intact
  logic [1:0] inest_ff;
  logic int_ff, nest_fault_ff;
  logic [15:0] filt_ff [AIN_N];
  logic [15:0] ain_ff, aout_ff, adc0_ff, adc2_ff;
  logic [7:0] loc_mem [LOC_ENT*LOC_BYTES];
  logic [7:0] loc_rd_ff;
  logic [ENT_W-1:0] ent;
  scs_addr_t loc_op;
  logic [15:0] loc_off;
  logic [9:0] loc_idx;
  logic [AIN_N-1:0] exp_img_ff;
  logic fail_ff, comm_ff;

  // Entity index: main, eight main nesting levels, interrupt, its one nesting level
  function automatic logic [ENT_W-1:0] ent_of(input logic in_int, input logic [3:0] lvl);
    ent_of = in_int ? ENT_INT + lvl[ENT_W-1:0] : ENT_MAIN + lvl[ENT_W-1:0];
  endfunction

  // Byte offset of an operand; device areas carry a device number, not a byte
  function automatic logic [15:0] op_offset(input scs_addr_t op);
    op_offset = op.byte_addr;
    if (op.area == AREA_DEV) op_offset = {8'h00, op.byte_addr[7:0]};
    else if (op.size == SZ_BIT) op_offset = op.byte_addr;
  endfunction

  // Pins pass two flops before any logic reads them
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
    end else begin
      din_s1_ff <= DIN_PINS;
      din_s2_ff <= din_s1_ff;
    end
  end

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_INPUT: nxt_phase = RUN_MODE ? PH_EXEC : PH_COMM;
      PH_EXEC: if (!int_ff && PROG_REQ.end_instr) nxt_phase = PH_COMM;
      PH_COMM: if (!int_ff) nxt_phase = PH_TEST;
      PH_TEST: if (!int_ff) nxt_phase = PH_OUTPUT;
      PH_OUTPUT: if (!int_ff) nxt_phase = PH_INPUT;
      default: nxt_phase = PH_INPUT;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) phase_ff <= PH_INPUT;
    else phase_ff <= nxt_phase;
  end

  // Input image: only sampling or an immediate read may change it
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) in_img_ff <= '0;
    else if (phase_ff == PH_INPUT || IMM_IN_RD) in_img_ff <= din_s2_ff;
  end

  // Output image and pins; immediate writes bypass the scan end
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      out_img_ff <= '0;
      dout_ff <= '0;
    end else begin
      if (IMG_WR || IMM_OUT_WR) out_img_ff <= IMG_OUT_DATA;
      if (IMM_OUT_WR) dout_ff <= IMG_OUT_DATA;
      else if (phase_ff == PH_OUTPUT && !int_ff) dout_ff <= out_img_ff;
    end
  end

  // Program counter and nesting
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_ff <= '0;
      nest_ff <= '0;
      inest_ff <= '0;
      nest_fault_ff <= 1'b0;
    end else begin
      if (phase_ff == PH_INPUT) pc_ff <= '0;
      else if (phase_ff == PH_EXEC && !int_ff && PROG_REQ.step) pc_ff <= pc_ff + 1'b1;
      if (INT_EVENT && !int_ff) inest_ff <= '0;
      else if (PROG_REQ.call && int_ff) begin
        if (inest_ff < 2'(INT_NEST)) inest_ff <= inest_ff + 1'b1;
        else nest_fault_ff <= 1'b1;
      end else if (PROG_REQ.ret && int_ff && inest_ff != '0) inest_ff <= inest_ff - 1'b1;
      if (PROG_REQ.call && !int_ff && phase_ff == PH_EXEC) begin
        if (nest_ff < 4'(MAIN_NEST)) nest_ff <= nest_ff + 1'b1;
        else nest_fault_ff <= 1'b1;
      end else if (PROG_REQ.ret && !int_ff && nest_ff != '0) nest_ff <= nest_ff - 1'b1;
    end
  end

  // Interrupt routine may begin in any phase
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) int_ff <= 1'b0;
    else if (INT_EVENT) int_ff <= 1'b1;
    else if (INT_DONE) int_ff <= 1'b0;
  end

  // Local memory, one 64-byte slice per entity
  // Interrupt slices sit above the main ones, so main data survives an interrupt
  assign ent = int_ff ? ent_of(1'b1, 4'(inest_ff)) : ent_of(1'b0, nest_ff);
  assign loc_op = '{area: AREA_LOCAL, size: SZ_BYTE, byte_addr: 16'(LOC_ADDR), bit_num: 3'h0};
  assign loc_off = op_offset(loc_op);
  assign loc_idx = 10'(ent) * 10'(LOC_BYTES) + 10'(loc_off[LOC_AW-1:0]);
  always_ff @(posedge CLK_SYS) begin
    if (LOC_WR) loc_mem[loc_idx] <= LOC_WDATA;
    loc_rd_ff <= loc_mem[loc_idx];
  end

  // Analog filter per point, refreshed once per scan
  genvar gi;
  generate
    for (gi = 0; gi < AIN_N; gi++) begin : g_filt
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) filt_ff[gi] <= RST_WORD;
        else if (phase_ff == PH_INPUT && AIN_FILT_EN[gi])
          // Sum kept at 17 bits so two full-range unsigned words cannot wrap
          filt_ff[gi] <= 16'((17'(filt_ff[gi]) + 17'(AIN_MODULE[gi*16 +: 16])) >> 1);
      end
    end
  endgenerate

  // Program access: held filtered value, or a fresh module read
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) ain_ff <= RST_WORD;
    else if (AIN_RD) ain_ff <= AIN_FILT_EN[AIN_SEL] ? filt_ff[AIN_SEL]
                                : AIN_MODULE[AIN_SEL*16 +: 16];
  end

  // On-board words follow the converter every scan, no filter needed
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      adc0_ff <= RST_WORD;
      adc2_ff <= RST_WORD;
    end else if (phase_ff == PH_INPUT) begin
      adc0_ff <= ADC_WORD0;
      adc2_ff <= ADC_WORD2;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) aout_ff <= RST_WORD;
    else if (AOUT_WR) aout_ff <= AOUT_WDATA;
  end

  // Communications and self-test
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      comm_ff <= 1'b0;
      exp_img_ff <= '0;
      fail_ff <= 1'b0;
    end else begin
      comm_ff <= (phase_ff == PH_COMM) && COMM_PENDING;
      if (phase_ff == PH_TEST) begin
        exp_img_ff <= EXP_STATUS;
        fail_ff <= !CPU_OK;
      end
    end
  end

  assign DOUT_PINS = dout_ff;
  assign IMG_IN_DATA = in_img_ff;
  assign PROG_PC = pc_ff;
  assign PROG_EXEC = (phase_ff == PH_EXEC) && !int_ff;
  assign NEST_FAULT = nest_fault_ff;
  assign INT_ACTIVE = int_ff;
  assign LOC_RDATA = loc_rd_ff;
  assign AIN_DATA = ain_ff;
  assign ONBOARD_WORD_ZERO = adc0_ff;
  assign ONBOARD_WORD_TWO = adc2_ff;
  assign AOUT_DATA = aout_ff;
  assign COMM_SERVICE = comm_ff;
  assign EXP_STATUS_IMG = exp_img_ff;
  assign SELF_TEST_FAIL = fail_ff;
  assign SCAN_PHASE = 3'(phase_ff);

  chk_phase_order: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_TEST && !int_ff |=> phase_ff == PH_OUTPUT) else $error("phase order");
  chk_input_sample: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_INPUT |=> in_img_ff == $past(din_s2_ff)) else $error("input not sampled");
  chk_output_copy: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_OUTPUT && !int_ff && !IMM_OUT_WR |=> dout_ff == $past(out_img_ff))
    else $error("output not copied");
  chk_stop_skip: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_INPUT && !RUN_MODE |=> phase_ff == PH_COMM) else $error("stop ran program");
  chk_nest_limit: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    inest_ff <= 2'(INT_NEST))
    else $error("interrupt nesting too deep");
  chk_main_nest: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    nest_ff <= 4'(MAIN_NEST))
    else $error("main nesting too deep");
  chk_fault_sticky: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    nest_fault_ff |=> nest_fault_ff)
    else $error("nest fault dropped");
  chk_img_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff != PH_INPUT && !IMM_IN_RD |=> $stable(in_img_ff)) else $error("image changed");
  chk_aout_now: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    AOUT_WR |=> aout_ff == $past(AOUT_WDATA)) else $error("analog out late");
  chk_int_any: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    INT_EVENT |=> int_ff) else $error("interrupt missed");
  chk_int_done: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    INT_DONE && !INT_EVENT |=> !int_ff)
    else $error("interrupt not ended");
  chk_phase_stall: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    int_ff && phase_ff != PH_INPUT |=> phase_ff == $past(phase_ff))
    else $error("phase moved in interrupt");
  chk_filter_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !(phase_ff == PH_INPUT && AIN_FILT_EN[0]) |=> $stable(filt_ff[0]))
    else $error("filter moved off scan");
  chk_filt_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    AIN_RD && AIN_FILT_EN[AIN_SEL] |=> ain_ff == $past(filt_ff[AIN_SEL]))
    else $error("filtered read wrong");
  chk_fresh_read: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    AIN_RD && !AIN_FILT_EN[AIN_SEL] |=> ain_ff == $past(AIN_MODULE[AIN_SEL*16 +: 16]))
    else $error("fresh read wrong");
  chk_onboard: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_INPUT |=> adc0_ff == $past(ADC_WORD0) && adc2_ff == $past(ADC_WORD2))
    else $error("onboard word stale");
  chk_pc_start: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_INPUT |=> pc_ff == '0)
    else $error("program not from start");
  chk_pc_step: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_EXEC && !int_ff && PROG_REQ.step |=> pc_ff == 8'($past(pc_ff) + 1'b1))
    else $error("program step lost");
  chk_imm_in: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    IMM_IN_RD |=> in_img_ff == $past(din_s2_ff))
    else $error("immediate read lost");
  chk_imm_out: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    IMM_OUT_WR |=> dout_ff == $past(IMG_OUT_DATA))
    else $error("immediate write lost");
  chk_loc_scope: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    ent < 4'(LOC_ENT))
    else $error("local entity out of range");
  chk_loc_bound: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    loc_idx < 10'(LOC_ENT * LOC_BYTES))
    else $error("local index out of range");
  chk_comm_serve: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_COMM && COMM_PENDING |=> comm_ff)
    else $error("message not serviced");
  chk_self_test: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    phase_ff == PH_TEST |=> exp_img_ff == $past(EXP_STATUS) && fail_ff == !$past(CPU_OK))
    else $error("self-test not collected");
endmodule

// ### rtl/scs_pkg.sv
// Package for the scan-cycle sequencer: constants, phases and carriers
package scs_pkg;
  localparam int DIN_W = 16;
  localparam int DOUT_W = 16;
  localparam int AIN_N = 4;
  localparam int AW = 16;
  localparam int LOC_ENT = 11;
  localparam int LOC_BYTES = 64;
  localparam int MAIN_NEST = 8;
  localparam int INT_NEST = 1;
  localparam int ENT_W = 4;
  localparam int LOC_AW = 6;
  localparam int PC_W = 8;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] UBYTE_MAX = 8'hFF;
  localparam logic [15:0] UWORD_MAX = 16'hFFFF;
  localparam logic [15:0] SWORD_MIN = 16'h8000;
  localparam logic [15:0] SWORD_MAX = 16'h7FFF;
  localparam logic [ENT_W-1:0] ENT_MAIN = 4'h0;
  localparam logic [ENT_W-1:0] ENT_INT = 4'h9;

  typedef enum {PH_INPUT, PH_EXEC, PH_COMM, PH_TEST, PH_OUTPUT} scs_phase_t;

  // Memory area identifiers for byte.bit and sized access
  typedef enum logic [2:0] {
    AREA_IN, AREA_OUT, AREA_VAR, AREA_BIT, AREA_FLAGS, AREA_LOCAL, AREA_DEV
  } scs_area_t;
  typedef enum logic [1:0] {SZ_BIT, SZ_BYTE, SZ_WORD, SZ_DWORD} scs_size_t;

  // Operand address: area, size, byte address (or device number) and bit number
  typedef struct packed {
    scs_area_t area;
    scs_size_t size;
    logic [15:0] byte_addr;
    logic [2:0] bit_num;
  } scs_addr_t;

  // Program-side request from the instruction engine
  typedef struct packed {
    logic step;
    logic end_instr;
    logic call;
    logic ret;
  } scs_prog_t;
endpackage

// ### sim/scs_field_model.sv
// Field-side model: sensors, expansion analog modules, converter, module status
`timescale 1ns/1ps
module scs_field_model (
  // Clock and update request from the bench
  input wire logic clk,
  input wire logic load,
  input wire logic [31:0] rnd,
  // Field values seen by the sequencer
  output logic [15:0] din,
  output logic [63:0] ain_mod,
  output logic [15:0] adc0,
  output logic [15:0] adc2,
  output logic [3:0] exp_st
);
  initial begin
    din = 16'h0000;
    ain_mod = 64'h0;
    adc0 = 16'h0000;
    adc2 = 16'hFFFF;
    exp_st = 4'h0;
  end
  // Values change off the bench's drive edge, like real sensors drifting
  always @(posedge clk) begin
    if (load) begin
      din <= rnd[15:0];
      ain_mod <= {rnd, ~rnd};
      adc0 <= rnd[31:16];
      adc2 <= ~rnd[31:16];
      exp_st <= rnd[3:0];
    end
  end
endmodule

// ### sim/tb.sv
// Self-checking bench for the scan-cycle sequencer
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module tb;
  import scs_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, run = 1'h1, load = 1'h0, cpu_ok = 1'h1, cpend = 1'h1;
  logic iwr = 1'h0, iird = 1'h0, iowr = 1'h0, iev = 1'h0, idone = 1'h0;
  logic lwr = 1'h0, ard = 1'h0, awr = 1'h0;
  scs_prog_t req = '0;
  logic [15:0] odat = 16'h0000, awdat = 16'h0000, out_n = 16'h0000;
  logic [5:0] laddr = 6'h05;
  logic [7:0] lwdat = 8'h00, pc, lrd;
  logic [3:0] fen = 4'h0, eimg, est, est_m = 4'h0;
  logic [1:0] asel = 2'h0;
  logic [31:0] rnd = 32'h0;
  logic [15:0] dout, iin, adat, ow0, ow2, aout, din, adc0, adc2;
  logic [15:0] din_m = 16'h0000, out_m = 16'h0000, adc_m = 16'h0000;
  logic [63:0] amod;
  logic [2:0] ph;
  logic [15:0] filt_m [4] = '{4{16'h0000}};
  logic pex, nf, iact, csvc, sfail, seen;
  int n_mismatch = 0, tests_run = 0, seed = 32'h1B210D82;
  scs_sequencer u_dut (.CLK_SYS(clk), .ARST_N(rst_n), .RUN_MODE(run), .DIN_PINS(din),
    .DOUT_PINS(dout), .PROG_REQ(req), .PROG_PC(pc), .PROG_EXEC(pex), .NEST_FAULT(nf),
    .IMG_WR(iwr), .IMG_OUT_DATA(odat), .IMM_IN_RD(iird), .IMM_OUT_WR(iowr), .IMG_IN_DATA(iin),
    .INT_EVENT(iev), .INT_DONE(idone), .INT_ACTIVE(iact), .LOC_WR(lwr), .LOC_ADDR(laddr),
    .LOC_WDATA(lwdat), .LOC_RDATA(lrd), .AIN_FILT_EN(fen), .AIN_RD(ard), .AIN_SEL(asel),
    .AIN_MODULE(amod), .ADC_WORD0(adc0), .ADC_WORD2(adc2), .AIN_DATA(adat),
    .ONBOARD_WORD_ZERO(ow0), .ONBOARD_WORD_TWO(ow2), .AOUT_WR(awr), .AOUT_WDATA(awdat),
    .AOUT_DATA(aout), .COMM_PENDING(cpend), .COMM_SERVICE(csvc), .CPU_OK(cpu_ok),
    .EXP_STATUS(est), .EXP_STATUS_IMG(eimg), .SELF_TEST_FAIL(sfail), .SCAN_PHASE(ph));
  scs_field_model u_field (.clk(clk), .load(load), .rnd(rnd), .din(din), .ain_mod(amod),
    .adc0(adc0), .adc2(adc2), .exp_st(est));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task tick();
    @(negedge clk);
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bounded wait so a stuck phase shows up as a mismatch, not a hang
  task wph(input int p);
    int i;
    for (i = 0; i < 100 && ph !== p[2:0]; i++) tick();
    `CHK("phase", p[2:0], ph)
  endtask
  task fresh();
    rnd = $random(seed);
    load = 1'h1;
    tick();
    load = 1'h0;
  endtask
  task extras();
    int k;
    fresh();
    repeat (4) tick();
    iird = 1'h1;
    tick();
    iird = 1'h0;
    tick();
    `CHK("imm_in", rnd[15:0], iin)
    out_n = ~rnd[15:0];
    odat = out_n;
    iowr = 1'h1;
    tick();
    iowr = 1'h0;
    tick();
    `CHK("imm_out", out_n, dout)
    awdat = rnd[31:16];
    awr = 1'h1;
    tick();
    awr = 1'h0;
    `CHK("aout", rnd[31:16], aout)
    fen = 4'h5;
    ard = 1'h1;
    for (k = 0; k < 4; k++) begin
      asel = k[1:0];
      tick();
      tick();
      `CHK("ain", (fen[k] ? filt_m[k] : amod[k*16+:16]), adat)
    end
    ard = 1'h0;
    lwdat = 8'h5A;
    lwr = 1'h1;
    tick();
    lwr = 1'h0;
    req.call = 1'h1;
    tick();
    req.call = 1'h0;
    lwdat = 8'hA5;
    lwr = 1'h1;
    tick();
    lwr = 1'h0;
    req.ret = 1'h1;
    tick();
    req.ret = 1'h0;
    tick();
    tick();
    `CHK("local", 8'h5A, lrd)
  endtask
  task scan(input int mode);
    int k;
    cpend = (mode != 0);
    wph(1);
    `CHK("pc0", 8'h00, pc)
    `CHK("exec", 1'h1, pex)
    `CHK("img_in", din_m, iin)
    `CHK("onboard0", adc_m, ow0)
    `CHK("onboard2", ~adc_m, ow2)
    `CHK("exp_img", est_m, eimg)
    `CHK("self_test", 1'h0, sfail)
    fresh();
    out_n = rnd[31:16] ^ 16'h5A3C;
    odat = out_n;
    iwr = 1'h1;
    req.step = 1'h1;
    for (k = 1; k <= 5; k++) begin
      tick();
      iwr = 1'h0;
      `CHK("pc", k[7:0], pc)
    end
    req.step = 1'h0;
    `CHK("img_hold", din_m, iin)
    `CHK("dout_hold", out_m, dout)
    if (mode == 1) extras();
    if (mode == 2) begin
      asel = 2'h0;
      ard = 1'h1;
      tick();
      ard = 1'h0;
      `CHK("ain_filt", filt_m[0], adat)
      req.call = 1'h1;
      repeat (8) tick();
      `CHK("nest8", 1'h0, nf)
      tick();
      req.call = 1'h0;
      `CHK("nest9", 1'h1, nf)
    end
    cpu_ok = (mode != 2);
    req.end_instr = 1'h1;
    tick();
    req.end_instr = 1'h0;
    wph(2);
    wph(3);
    `CHK("comm_svc", cpend, csvc)
    wph(4);
    if (mode == 3) run = 1'h0;
    wph(0);
    `CHK("dout", out_n, dout)
    `CHK("self_fail", (mode == 2), sfail)
    cpu_ok = 1'h1;
    out_m = out_n;
    din_m = rnd[15:0];
    adc_m = rnd[31:16];
    est_m = rnd[3:0];
    for (k = 0; k < 4; k++) begin
      if (fen[k]) filt_m[k] = 16'((17'(filt_m[k]) + 17'(amod[k*16+:16])) >> 1);
    end
  endtask
  initial begin
    #(25 * 20000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    int k;
    repeat (6) tick();
    rst_n = 1'h1;
    `CHK("rst_phase", 3'h0, ph)
    `CHK("rst_dout", 16'h0000, dout)
    scan(0);
    scan(3);
    seen = 1'h0;
    for (k = 0; k < 4; k++) begin
      tick();
      `CHK("stop_phase", 3'(k == 3 ? 0 : k + 2), ph)
      `CHK("stop_exec", 1'h0, pex)
      if (csvc === 1'h1) seen = 1'h1;
      if (ph === 3'h4) run = 1'h1;
    end
    `CHK("comm", 1'h1, seen)
    scan(1);
    scan(2);
    rst_n = 1'h0;
    tick();
    tick();
    rst_n = 1'h1;
    out_m = 16'h0000;
    wph(1);
    iev = 1'h1;
    tick();
    iev = 1'h0;
    `CHK("int_act", 1'h1, iact)
    req.call = 1'h1;
    tick();
    `CHK("int_nest1", 1'h0, nf)
    tick();
    req.call = 1'h0;
    `CHK("int_nest2", 1'h1, nf)
    idone = 1'h1;
    tick();
    idone = 1'h0;
    `CHK("int_done", 1'h0, iact)
    req.end_instr = 1'h1;
    tick();
    req.end_instr = 1'h0;
    wph(0);
    end_of_test();
  end
endmodule
